// ---- src/gsio_router.sv ----
`timescale 1ns/100ps
`default_nettype none
module gsio_router (
	input wire logic MCLK_I,
	input wire logic RESET_I,
	// pins and remote link
	input wire logic [gsio_pkg::NUM_DIN-1:0] DIN_I,
	output logic [gsio_pkg::NUM_DOUT-1:0] DOUT_O,
	input wire logic [gsio_pkg::NUM_RIN-1:0] RIN_I,
	output logic [gsio_pkg::NUM_ROUT-1:0] ROUT_O,
	output logic EVENT_O,
	output logic IRQ_O,
	// register bus
	input wire logic [gsio_pkg::ADDR_W-1:0] AWADDR_I,
	input wire logic AWVALID_I,
	output logic AWREADY_O,
	input wire logic [31:0] WDATA_I,
	input wire logic [3:0] WSTRB_I,
	input wire logic WVALID_I,
	output logic WREADY_O,
	output logic [1:0] BRESP_O,
	output logic BVALID_O,
	input wire logic BREADY_I,
	input wire logic [gsio_pkg::ADDR_W-1:0] ARADDR_I,
	input wire logic ARVALID_I,
	output logic ARREADY_O,
	output logic [31:0] RDATA_O,
	output logic [1:0] RRESP_O,
	output logic RVALID_O,
	input wire logic RREADY_I
);
	import gsio_pkg::*;

	// field of a packed selection word
	function automatic logic [SEL_W-1:0] sel_of(input logic [63:0] word, input int k);
		sel_of = word[k*SEL_W +: SEL_W];
	endfunction

	// byte-lane merge of a write
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
		merge = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				merge[b*8 +: 8] = data[b*8 +: 8];
			end
		end
	endfunction

	// configuration registers
	logic [31:0] din_sel_q; // direct input functions
	logic [7:0] din_en_q; // direct input assigned
	logic [7:0] din_inv_q; // direct input invert
	logic [31:0] dout_sel_q; // direct output functions
	logic [7:0] dout_inv_q; // direct output invert
	logic [63:0] rin_sel_q; // remote input functions
	logic [15:0] rin_en_q; // remote input assigned
	logic [63:0] rout_sel_q; // remote output functions
	logic [3:0] evt_src_q; // event trigger source
	logic evt_en_q; // event trigger enable
	logic irq_stat_q; // sticky event status
	logic irq_mask_q; // event interrupt mask

	// routing state
	logic [NUM_DIN-1:0] din_s; // synchronised direct inputs
	logic [NUM_GSIG-1:0] gsig_d; // general signals next
	logic [NUM_GSIG-1:0] gsig_q; // general signals
	logic [NUM_GSIG-1:0] gsig_prev_q; // general signals one cycle back
	logic [NUM_DOUT-1:0] dout_d; // direct outputs next
	logic [NUM_ROUT-1:0] rout_d; // remote outputs next
	logic evt_rise; // source rose this cycle

	// bus state
	logic aw_full_q; // write address held
	logic w_full_q; // write data held
	logic [ADDR_W-1:0] aw_addr_q; // held write address
	logic [31:0] w_data_q; // held write data
	logic [3:0] w_strb_q; // held byte enables
	logic wr_go; // perform the write now
	logic wr_hit; // write address is mapped
	logic rd_go; // read taken this cycle
	logic [31:0] rd_word; // read mux output
	logic rd_hit; // read address is mapped
	logic stat_clr; // status read taken

	// pin inputs pass two flops first
	gsio_sync #(
		.W(NUM_DIN)
	) u_din_sync (
		.MCLK_I(MCLK_I),
		.RESET_I(RESET_I),
		.ASYNC_I(DIN_I),
		.SYNC_O(din_s)
	);

	// gather every assigned source into the general signals
	always_comb begin
		gsig_d = '0;
		for (int k = 0; k < NUM_DIN; k++) begin
			if (din_en_q[k]) begin
				gsig_d[sel_of({32'h0, din_sel_q}, k)] |= din_s[k] ^ din_inv_q[k];
			end
		end
		for (int k = 0; k < NUM_RIN; k++) begin
			if (rin_en_q[k]) begin
				gsig_d[sel_of(rin_sel_q, k)] |= RIN_I[k];
			end
		end
	end

	// drive terminals and remote bits from the general signals
	always_comb begin
		for (int k = 0; k < NUM_DOUT; k++) begin
			dout_d[k] = gsig_q[sel_of({32'h0, dout_sel_q}, k)] ^ dout_inv_q[k];
		end
		for (int k = 0; k < NUM_ROUT; k++) begin
			rout_d[k] = gsig_q[sel_of(rout_sel_q, k)];
		end
	end

	// registered routing stage
	always_ff @(posedge MCLK_I) begin
		if (RESET_I) begin
			gsig_q <= '0;
			gsig_prev_q <= '0;
			DOUT_O <= '0;
			ROUT_O <= '0;
		end else begin
			gsig_q <= gsig_d;
			gsig_prev_q <= gsig_q;
			DOUT_O <= dout_d;
			ROUT_O <= rout_d;
		end
	end

	// operation-data event on rising source
	assign evt_rise = evt_en_q && gsig_q[evt_src_q] && !gsig_prev_q[evt_src_q];

	// event pulse
	always_ff @(posedge MCLK_I) begin
		if (RESET_I) begin
			EVENT_O <= 1'b0;
		end else begin
			EVENT_O <= evt_rise;
		end
	end

	// sticky status, set wins over read clear
	always_ff @(posedge MCLK_I) begin
		if (RESET_I) begin
			irq_stat_q <= 1'b0;
			IRQ_O <= 1'b0;
		end else begin
			irq_stat_q <= evt_rise | (irq_stat_q & !stat_clr);
			IRQ_O <= (evt_rise | (irq_stat_q & !stat_clr)) & irq_mask_q;
		end
	end

	// write channel capture and response
	assign wr_go = aw_full_q && w_full_q && !BVALID_O;
	always_ff @(posedge MCLK_I) begin
		if (RESET_I) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			AWREADY_O <= 1'b1;
			WREADY_O <= 1'b1;
			BVALID_O <= 1'b0;
			BRESP_O <= RESP_OKAY;
			aw_addr_q <= '0;
			w_data_q <= '0;
			w_strb_q <= '0;
		end else begin
			// address taken
			if (AWVALID_I && AWREADY_O) begin
				aw_full_q <= 1'b1;
				AWREADY_O <= 1'b0;
				aw_addr_q <= AWADDR_I;
			end
			// data taken
			if (WVALID_I && WREADY_O) begin
				w_full_q <= 1'b1;
				WREADY_O <= 1'b0;
				w_data_q <= WDATA_I;
				w_strb_q <= WSTRB_I;
			end
			// both held: answer
			if (wr_go) begin
				BVALID_O <= 1'b1;
				BRESP_O <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end
			// answer accepted: reopen
			if (BVALID_O && BREADY_I) begin
				BVALID_O <= 1'b0;
				aw_full_q <= 1'b0;
				w_full_q <= 1'b0;
				AWREADY_O <= 1'b1;
				WREADY_O <= 1'b1;
			end
		end
	end

	// write decode into configuration
	always_comb begin
		case ({aw_addr_q[ADDR_W-1:2], 2'b00})
			ADDR_DIN_SEL, ADDR_DIN_CFG, ADDR_DOUT_SEL, ADDR_DOUT_INV, ADDR_RIN_SEL_LO, ADDR_RIN_SEL_HI,
			ADDR_RIN_EN, ADDR_ROUT_SEL_LO, ADDR_ROUT_SEL_HI, ADDR_EVT_CFG, ADDR_IRQ_STAT, ADDR_IRQ_MASK,
			ADDR_STATE: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	// configuration registers
	always_ff @(posedge MCLK_I) begin
		if (RESET_I) begin
			din_sel_q <= DIN_SEL_RST;
			din_en_q <= DIN_EN_RST;
			din_inv_q <= DIN_INV_RST;
			dout_sel_q <= DOUT_SEL_RST;
			dout_inv_q <= DOUT_INV_RST;
			rin_sel_q <= RIN_SEL_RST;
			rin_en_q <= RIN_EN_RST;
			rout_sel_q <= ROUT_SEL_RST;
			evt_src_q <= EVT_SRC_RST;
			evt_en_q <= EVT_EN_RST;
			irq_mask_q <= IRQ_MASK_RST;
		end else if (wr_go) begin
			case ({aw_addr_q[ADDR_W-1:2], 2'b00})
				ADDR_DIN_SEL: din_sel_q <= merge(din_sel_q, w_data_q, w_strb_q);
				ADDR_DIN_CFG: begin
					din_en_q <= w_strb_q[0] ? w_data_q[7:0] : din_en_q;
					din_inv_q <= w_strb_q[1] ? w_data_q[DIN_INV_LSB +: 8] : din_inv_q;
				end
				ADDR_DOUT_SEL: dout_sel_q <= merge(dout_sel_q, w_data_q, w_strb_q);
				ADDR_DOUT_INV: dout_inv_q <= w_strb_q[0] ? w_data_q[7:0] : dout_inv_q;
				ADDR_RIN_SEL_LO: rin_sel_q[31:0] <= merge(rin_sel_q[31:0], w_data_q, w_strb_q);
				ADDR_RIN_SEL_HI: rin_sel_q[63:32] <= merge(rin_sel_q[63:32], w_data_q, w_strb_q);
				ADDR_RIN_EN: begin
					rin_en_q[7:0] <= w_strb_q[0] ? w_data_q[7:0] : rin_en_q[7:0];
					rin_en_q[15:8] <= w_strb_q[1] ? w_data_q[15:8] : rin_en_q[15:8];
				end
				ADDR_ROUT_SEL_LO: rout_sel_q[31:0] <= merge(rout_sel_q[31:0], w_data_q, w_strb_q);
				ADDR_ROUT_SEL_HI: rout_sel_q[63:32] <= merge(rout_sel_q[63:32], w_data_q, w_strb_q);
				ADDR_EVT_CFG: begin
					evt_src_q <= w_strb_q[0] ? w_data_q[3:0] : evt_src_q;
					evt_en_q <= w_strb_q[1] ? w_data_q[EVT_EN_BIT] : evt_en_q;
				end
				ADDR_IRQ_MASK: irq_mask_q <= w_strb_q[0] ? w_data_q[0] : irq_mask_q;
				// status and state are read-only
				default: begin
				end
			endcase
		end
	end

	// read mux
	always_comb begin
		rd_word = 32'h0;
		rd_hit = 1'b1;
		case ({ARADDR_I[ADDR_W-1:2], 2'b00})
			ADDR_DIN_SEL: rd_word = din_sel_q;
			ADDR_DIN_CFG: rd_word = {16'h0, din_inv_q, din_en_q};
			ADDR_DOUT_SEL: rd_word = dout_sel_q;
			ADDR_DOUT_INV: rd_word = {24'h0, dout_inv_q};
			ADDR_RIN_SEL_LO: rd_word = rin_sel_q[31:0];
			ADDR_RIN_SEL_HI: rd_word = rin_sel_q[63:32];
			ADDR_RIN_EN: rd_word = {16'h0, rin_en_q};
			ADDR_ROUT_SEL_LO: rd_word = rout_sel_q[31:0];
			ADDR_ROUT_SEL_HI: rd_word = rout_sel_q[63:32];
			ADDR_EVT_CFG: rd_word = {23'h0, evt_en_q, 4'h0, evt_src_q};
			ADDR_IRQ_STAT: rd_word = {31'h0, irq_stat_q};
			ADDR_IRQ_MASK: rd_word = {31'h0, irq_mask_q};
			ADDR_STATE: rd_word = {8'h0, din_s, gsig_q};
			default: rd_hit = 1'b0;
		endcase
	end

	// read channel
	assign rd_go = ARVALID_I && ARREADY_O;
	assign stat_clr = rd_go && ({ARADDR_I[ADDR_W-1:2], 2'b00} == ADDR_IRQ_STAT);
	always_ff @(posedge MCLK_I) begin
		if (RESET_I) begin
			ARREADY_O <= 1'b1;
			RVALID_O <= 1'b0;
			RDATA_O <= 32'h0;
			RRESP_O <= RESP_OKAY;
		end else begin
			// address taken: answer on the same edge
			if (rd_go) begin
				ARREADY_O <= 1'b0;
				RVALID_O <= 1'b1;
				RDATA_O <= rd_word;
				RRESP_O <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end
			// data accepted: reopen
			if (RVALID_O && RREADY_I) begin
				RVALID_O <= 1'b0;
				ARREADY_O <= 1'b1;
			end
		end
	end

	// remote bit 0 on signal 0 reaches direct output 0 in two edges
	AST_RIN_TO_DOUT: assert property (@(posedge MCLK_I) disable iff (RESET_I)
		(RIN_I[0] && rin_en_q[0] && rin_sel_q[3:0] == 4'h0 && dout_sel_q[3:0] == 4'h0 && !dout_inv_q[0]
		&& !wr_go) |=> ##1 DOUT_O[0])
		else $error("direct output 0 did not follow remote input bit 0");

	// inverted output goes low for an active signal
	AST_DOUT_INV: assert property (@(posedge MCLK_I) disable iff (RESET_I)
		(RIN_I[0] && rin_en_q[0] && rin_sel_q[3:0] == 4'h0 && dout_sel_q[3:0] == 4'h0 && dout_inv_q[0]
		&& !wr_go) |=> ##1 !DOUT_O[0])
		else $error("inverted direct output 0 not low");

	// direct input 1 on signal 1 reported in remote output 1
	AST_DIN_TO_ROUT: assert property (@(posedge MCLK_I) disable iff (RESET_I)
		(DIN_I[1] && din_en_q[1] && din_sel_q[7:4] == 4'h1 && !din_inv_q[1] && rout_sel_q[7:4] == 4'h1
		&& !wr_go) [*4] |=> ROUT_O[1])
		else $error("remote output 1 did not follow direct input 1");

	// inverted input reports its low level as 1
	AST_DIN_INV: assert property (@(posedge MCLK_I) disable iff (RESET_I)
		(!DIN_I[1] && din_en_q[1] && din_sel_q[7:4] == 4'h1 && din_inv_q[1] && rout_sel_q[7:4] == 4'h1
		&& !wr_go) [*4] |=> ROUT_O[1])
		else $error("inverted direct input 1 not reported as 1");

	// rising source gives one event pulse next edge
	AST_EVENT: assert property (@(posedge MCLK_I) disable iff (RESET_I)
		(evt_en_q && $rose(gsig_q[2]) && evt_src_q == 4'h2) |=> (EVENT_O ##1 !EVENT_O || $rose(gsig_q[2])))
		else $error("event pulse missing for rising source");

	// outputs leave reset cleared
	AST_RESET_CLEAR: assert property (@(posedge MCLK_I) disable iff (RESET_I)
		$fell(RESET_I) |-> (DOUT_O == '0 && ROUT_O == '0 && !EVENT_O && !IRQ_O))
		else $error("outputs not cleared after reset");

	// unmasked event raises the interrupt
	AST_IRQ: assert property (@(posedge MCLK_I) disable iff (RESET_I)
		(EVENT_O && irq_mask_q) |-> IRQ_O ##1 (IRQ_O || !irq_mask_q || $past(stat_clr)))
		else $error("interrupt did not follow unmasked event");

	// write answer holds until taken
	AST_BVALID_HOLD: assert property (@(posedge MCLK_I) disable iff (RESET_I)
		(BVALID_O && !BREADY_I) |=> (BVALID_O && $stable(BRESP_O)))
		else $error("write response dropped before ready");
endmodule
`default_nettype wire

// ---- src/gsio_pkg.sv ----
package gsio_pkg;
	// sizes of the routing fabric
	localparam int NUM_GSIG = 16; // general signals 0..15
	localparam int NUM_DIN = 8; // direct input terminals
	localparam int NUM_DOUT = 8; // direct output terminals
	localparam int NUM_RIN = 16; // remote input bits from the master
	localparam int NUM_ROUT = 16; // remote output bits to the master
	localparam int SEL_W = 4; // width of one function-selection field
	localparam int ADDR_W = 8; // register bus address width
	localparam int SYNC_STAGES = 2; // flip-flops ahead of pin logic

	// register byte offsets
	localparam logic [ADDR_W-1:0] ADDR_DIN_SEL = 8'h00; // direct input function, 4 bits each
	localparam logic [ADDR_W-1:0] ADDR_DIN_CFG = 8'h04; // [7:0] assign enable, [15:8] invert
	localparam logic [ADDR_W-1:0] ADDR_DOUT_SEL = 8'h08; // direct output function, 4 bits each
	localparam logic [ADDR_W-1:0] ADDR_DOUT_INV = 8'h0C; // [7:0] output invert
	localparam logic [ADDR_W-1:0] ADDR_RIN_SEL_LO = 8'h10; // remote input bits 0..7
	localparam logic [ADDR_W-1:0] ADDR_RIN_SEL_HI = 8'h14; // remote input bits 8..15
	localparam logic [ADDR_W-1:0] ADDR_RIN_EN = 8'h18; // [15:0] remote input assign enable
	localparam logic [ADDR_W-1:0] ADDR_ROUT_SEL_LO = 8'h1C; // remote output bits 0..7
	localparam logic [ADDR_W-1:0] ADDR_ROUT_SEL_HI = 8'h20; // remote output bits 8..15
	localparam logic [ADDR_W-1:0] ADDR_EVT_CFG = 8'h24; // [3:0] event source, [8] enable
	localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 8'h28; // [0] event seen, cleared by read
	localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h2C; // [0] event interrupt enable
	localparam logic [ADDR_W-1:0] ADDR_STATE = 8'h30; // [15:0] general signals, [23:16] inputs

	// field positions
	localparam int DIN_INV_LSB = 8; // invert field in direct input config
	localparam int EVT_EN_BIT = 8; // enable bit in event config
	localparam int STATE_DIN_LSB = 16; // direct input field in state word

	// reset values: terminal k defaults to general signal k
	localparam logic [31:0] DIN_SEL_RST = 32'h76543210;
	localparam logic [7:0] DIN_EN_RST = 8'h00;
	localparam logic [7:0] DIN_INV_RST = 8'h00;
	localparam logic [31:0] DOUT_SEL_RST = 32'h76543210;
	localparam logic [7:0] DOUT_INV_RST = 8'h00;
	localparam logic [63:0] RIN_SEL_RST = 64'hFEDCBA98_76543210;
	localparam logic [15:0] RIN_EN_RST = 16'hFFFF;
	localparam logic [63:0] ROUT_SEL_RST = 64'hFEDCBA98_76543210;
	localparam logic [3:0] EVT_SRC_RST = 4'h2;
	localparam logic EVT_EN_RST = 1'b0;
	localparam logic IRQ_MASK_RST = 1'b0;

	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- src/gsio_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
// two-stage synchroniser for asynchronous pin levels
module gsio_sync #(
	parameter int W = 8
) (
	input wire logic MCLK_I,
	input wire logic RESET_I,
	input wire logic [W-1:0] ASYNC_I,
	output logic [W-1:0] SYNC_O
);
	logic [W-1:0] meta_q; // first stage, read only by second stage

	// capture then re-time
	always_ff @(posedge MCLK_I) begin
		if (RESET_I) begin
			meta_q <= '0;
			SYNC_O <= '0;
		end else begin
			meta_q <= ASYNC_I;
			SYNC_O <= meta_q;
		end
	end
endmodule
`default_nettype wire

// ---- bench/gsio_master_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// master controller side of the remote bit link
module gsio_master_model (
	input wire logic mclk_i,
	input wire logic [15:0] rout_i, // remote output bits reported by the router
	output logic [15:0] rin_o // remote input bits sent to the router
);
	logic [15:0] rin_q = 16'h0000; // bits the master currently commands

	assign rin_o = rin_q;

	// new command word lands just after a rising edge, then holds
	task automatic send(input logic [15:0] v);
		@(posedge mclk_i);
		rin_q <= v;
	endtask
endmodule
`default_nettype wire

// ---- bench/general_signal_io_router_test.sv ----
`timescale 1ns/100ps
`default_nettype none
module general_signal_io_router_test;
	import gsio_pkg::*;
	logic clk = 1'b0; // 200 MHz system clock
	logic rst = 1'b1; // synchronous reset
	logic [7:0] din = 8'h00; // direct input pins
	logic [7:0] dout;
	logic [15:0] rin, rout;
	logic evt, irq;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h00000000;
	logic [3:0] wstrb = 4'hF;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	int n_mismatch = 0;
	int tests_run = 0;
	logic [7:0] ra [11] = '{ADDR_DIN_SEL, ADDR_DIN_CFG, ADDR_DOUT_SEL, ADDR_DOUT_INV, ADDR_RIN_SEL_LO,
		ADDR_RIN_SEL_HI, ADDR_RIN_EN, ADDR_ROUT_SEL_LO, ADDR_ROUT_SEL_HI, ADDR_EVT_CFG, ADDR_IRQ_MASK};
	logic [31:0] rv [11] = '{DIN_SEL_RST, {16'h0000, DIN_INV_RST, DIN_EN_RST}, DOUT_SEL_RST,
		{24'h000000, DOUT_INV_RST}, RIN_SEL_RST[31:0], RIN_SEL_RST[63:32], {16'h0000, RIN_EN_RST},
		ROUT_SEL_RST[31:0], ROUT_SEL_RST[63:32], {23'h000000, EVT_EN_RST, 4'h0, EVT_SRC_RST},
		{31'h00000000, IRQ_MASK_RST}};

	gsio_router dut (.MCLK_I(clk), .RESET_I(rst), .DIN_I(din), .DOUT_O(dout), .RIN_I(rin), .ROUT_O(rout),
		.EVENT_O(evt), .IRQ_O(irq), .AWADDR_I(awaddr), .AWVALID_I(awvalid), .AWREADY_O(awready),
		.WDATA_I(wdata), .WSTRB_I(wstrb), .WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp),
		.BVALID_O(bvalid), .BREADY_I(bready), .ARADDR_I(araddr), .ARVALID_I(arvalid),
		.ARREADY_O(arready), .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready));

	gsio_master_model master (.mclk_i(clk), .rout_i(rout), .rin_o(rin));

	// free-running clock
	initial begin
		forever #2.5 clk = ~clk;
	end

	// compare one value and count it
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic print_verdict();
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// k rising edges, then stop at the settled falling edge
	task automatic settle(input int k);
		repeat (k) @(posedge clk);
		@(negedge clk);
	endtask

	// bus write: address and data offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_done, w_done, aw_rdy, w_rdy;
		int n;
		aw_done = 1'b0;
		w_done = 1'b0;
		n = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_done && w_done) && n < 50) begin
			@(negedge clk);
			aw_rdy = awready & ~aw_done;
			w_rdy = wready & ~w_done;
			@(posedge clk);
			if (aw_rdy) begin
				awvalid <= 1'b0;
				aw_done = 1'b1;
			end
			if (w_rdy) begin
				wvalid <= 1'b0;
				w_done = 1'b1;
			end
			n++;
		end
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (bvalid !== 1'b1 && n < 50);
		check("write response", {bvalid, bresp}, {1'b1, er});
		@(posedge clk);
		bready <= 1'b0;
	endtask

	// bus read with expected data and response
	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge clk);
			n++;
		end while (arready !== 1'b1 && n < 50);
		@(posedge clk);
		arvalid <= 1'b0;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (rvalid !== 1'b1 && n < 50);
		check("read data", rdata, ed);
		check("read response", {rvalid, rresp}, {1'b1, er});
		@(posedge clk);
		rready <= 1'b0;
	endtask

	// drive direct input pins just after an edge
	task automatic dset(input logic [7:0] v);
		@(posedge clk);
		din <= v;
	endtask

	// hang guard, far beyond the expected run length
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		print_verdict();
	end

	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		settle(0);
		check("outputs after reset", {dout, rout, evt, irq}, 26'h0000000);
		for (int i = 0; i < 11; i++) rd(ra[i], rv[i], RESP_OKAY);
		// remote bit to direct output and back, one register stage per hop
		master.send(16'h0001);
		settle(1);
		check("dout early", dout, 8'h00);
		settle(1);
		check("dout bit0", dout, 8'h01);
		for (int i = 0; i < 16; i++) begin
			master.send(16'h0001 << i);
			settle(2);
			check("rout walk", rout, 32'h1 << i);
			check("dout walk", dout, (i < 8) ? (32'h1 << i) : 32'h0);
		end
		master.send(16'h0000);
		settle(2);
		check("dout off", dout, 8'h00);
		// output inversion
		wr(ADDR_DOUT_INV, 32'h00000001, RESP_OKAY);
		settle(2);
		check("dout inverted", dout, 8'h01);
		master.send(16'h0001);
		settle(2);
		check("dout inverted on", dout, 8'h00);
		master.send(16'h0000);
		wr(ADDR_DOUT_INV, 32'h00000000, RESP_OKAY);
		// remote input bit 0 moved to general signal 3
		wr(ADDR_RIN_SEL_LO, 32'h76543213, RESP_OKAY);
		master.send(16'h0001);
		settle(2);
		check("rin remap", {dout, rout}, 24'h080008);
		master.send(16'h0000);
		wr(ADDR_RIN_SEL_LO, RIN_SEL_RST[31:0], RESP_OKAY);
		// remote output bit 0 reports general signal 5
		wr(ADDR_ROUT_SEL_LO, 32'h76543215, RESP_OKAY);
		master.send(16'h0020);
		settle(2);
		check("rout remap", rout, 16'h0021);
		master.send(16'h0000);
		wr(ADDR_ROUT_SEL_LO, ROUT_SEL_RST[31:0], RESP_OKAY);
		// direct input 1 reported to the master, plain then inverted
		wr(ADDR_DIN_CFG, 32'h00000002, RESP_OKAY);
		dset(8'h02);
		settle(4);
		check("direct_input_one on", rout, 16'h0002);
		dset(8'h00);
		settle(4);
		check("direct_input_one off", rout, 16'h0000);
		wr(ADDR_DIN_CFG, 32'h00000202, RESP_OKAY);
		settle(2);
		check("direct_input_one inv off", rout, 16'h0002);
		dset(8'h02);
		settle(4);
		check("direct_input_one inv on", rout, 16'h0000);
		wr(ADDR_DIN_SEL, 32'h76543250, RESP_OKAY);
		wr(ADDR_DIN_CFG, 32'h00000002, RESP_OKAY);
		settle(2);
		check("direct_input_one remap", rout, 16'h0020);
		dset(8'h00);
		wr(ADDR_DIN_SEL, DIN_SEL_RST, RESP_OKAY);
		// event from direct input 2 on general signal 2, with interrupt
		wr(ADDR_IRQ_MASK, 32'h00000001, RESP_OKAY);
		wr(ADDR_EVT_CFG, 32'h00000102, RESP_OKAY);
		wr(ADDR_DIN_CFG, 32'h00000004, RESP_OKAY);
		dset(8'h04);
		settle(3);
		check("event early", evt, 1'b0);
		settle(1);
		check("event pulse", {evt, irq}, 2'h3);
		settle(1);
		check("event one cycle", {evt, irq}, 2'h1);
		rd(ADDR_IRQ_STAT, 32'h00000001, RESP_OKAY);
		settle(1);
		check("irq cleared", irq, 1'b0);
		rd(ADDR_IRQ_STAT, 32'h00000000, RESP_OKAY);
		// byte lanes: only the invert lane of the input config is written
		@(posedge clk);
		wstrb <= 4'h2;
		wr(ADDR_DIN_CFG, 32'h0000AAFF, RESP_OKAY);
		wstrb <= 4'hF;
		rd(ADDR_DIN_CFG, 32'h0000AA04, RESP_OKAY);
		// refused and ignored accesses
		rd(8'h40, 32'h00000000, RESP_SLVERR);
		wr(8'h44, 32'hFFFFFFFF, RESP_SLVERR);
		wr(ADDR_STATE, 32'hFFFFFFFF, RESP_OKAY);
		print_verdict();
	end
endmodule
`default_nettype wire
